//--- design/pwm_da_map.svh
// Register offsets, field positions, reset values and counts of the pulse D/A block
`ifndef PWM_DA_MAP_SVH
`define PWM_DA_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFF_DATA_A      12'h000
`define OFF_DATA_B      12'h004
`define OFF_CTRL        12'h008
`define OFF_COUNT       12'h00C

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CTRL_CLKSEL_BIT 0
`define CTRL_PHASE_BIT  1
`define CTRL_OE_A_BIT   2
`define CTRL_OE_B_BIT   3
`define CTRL_RUN_BIT    6
`define CTRL_RSVD_MASK  8'h30
`define CTRL_WR_MASK    8'h4F

// ---------------------------------------------------------------
// Data register fields: value in [15:2], cycle select in bit 1
// ---------------------------------------------------------------
`define DATA_CYCSEL_BIT 1
`define DATA_WR_MASK    16'hFFFE

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_DATA        16'h0000
`define RST_CTRL        8'h30
`define RST_COUNT       14'h0000

// ---------------------------------------------------------------
// Counts and thresholds
// ---------------------------------------------------------------
`define COUNT_HOLD      14'h0003
`define HOLD_MAX_SHORT  16'h03FD
`define HOLD_MAX_LONG   16'h00FF
`define CLK_PERIOD_NS   10

`endif

//--- design/pwm_da_pkg.sv
// Types shared by the pulse D/A block
`default_nettype none

package pwm_da_pkg;

  typedef logic [13:0] count_t;
  typedef logic [15:0] data_t;
  typedef logic [7:0]  ctrl_t;

endpackage : pwm_da_pkg

`default_nettype wire

//--- design/pulse_channel.sv
// One channel of the pulse D/A: compares the shared counter with the data value
`default_nettype none
`include "pwm_da_map.svh"

module pulse_channel
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire pwm_da_pkg::count_t  count,
  input  wire pwm_da_pkg::data_t   data,
  input  wire logic                phase_select_bit,
  input  wire logic                output_enable,
  output var  logic                pin_r,
  output var  logic                pin_oe_r
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : rev8

  logic        pin_nxt;
  logic        pin_oe_nxt;
  logic [13:0] value;
  logic        cycle_select_bit;
  logic [7:0]  pos;
  logic [8:0]  duty;
  logic [7:0]  order;
  logic        add;
  logic        active;
  logic        hold;

  // ---------------------------------------------------------------
  // Waveform
  // ---------------------------------------------------------------
  always_comb
  begin
    value = data[15:2];
    cycle_select_bit = data[`DATA_CYCSEL_BIT];
    if (cycle_select_bit)
    begin
      // 64 basic pulses of 256 units
      pos   = count[7:0];
      duty  = {1'b0, value[13:6]};
      order = rev8({~count[13:8], 2'b00});
      add   = order[5:0] < value[5:0];
      hold  = data <= `HOLD_MAX_LONG;
    end
    else
    begin
      // 256 basic pulses of 64 units
      pos   = {2'b00, count[5:0]};
      duty  = {3'b000, value[13:8]};
      order = rev8(~count[13:6]);
      add   = order < value[7:0];
      hold  = data <= `HOLD_MAX_SHORT;
    end
    active = hold | ({1'b0, pos} < (duty + {8'h00, add}));
    pin_nxt    = output_enable & (~active ^ phase_select_bit);
    pin_oe_nxt = output_enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_r    <= 1'b0;
      pin_oe_r <= 1'b0;
    end
    else
    begin
      pin_r    <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

endmodule : pulse_channel

`default_nettype wire

//--- design/pwm_da_pulse_generator.sv
// Two-channel pulse-width D/A generator with APB register access
//
// Overview of operation
// - The data value sets the summed active (low) time over a cycle of 256 or 64 basic pulses.
// - Phase select 0 passes the waveform, 1 inverts it so the value sets the high time.
// - With cycle select 1 the duty comes from data bits 13..6 and placement from bits 5..0.
// - With cycle select 0 the duty comes from the upper six data bits, placement the next eight.
// - A basic pulse lasts 256 time units with cycle select 1 and 64 units with it 0.
// - Values up to 03FD (select 0) or 00FF (select 1) hold the output at its active level.
// - From 0401 (select 0) or 0103 (select 1) upward the active width is value times unit.
// - A full cycle is 16384 units; fixing low data bits at zero shortens its period.
// - With select 1 and placement 000001 the one extra pulse falls in basic pulse 63.
// - Each extra pulse lengthens the active part of its basic pulse by one time unit.
// - Clock select 0 makes the time unit one clock, 1 makes it two clocks.
// - The 14-bit counter counts while run control is 0 and stands at 0003 while it is 1.
// - Each channel drives its pin only while its own output enable is 1.
`default_nettype none
`include "pwm_da_map.svh"

module pwm_da_pulse_generator
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        pulse_pin_a,
  output var  logic        pulse_pin_a_oe,
  output var  logic        pulse_pin_b,
  output var  logic        pulse_pin_b_oe
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic addr_known(input logic [11:0] a);
    return (a == `OFF_DATA_A) || (a == `OFF_DATA_B) ||
           (a == `OFF_CTRL) || (a == `OFF_COUNT);
  endfunction : addr_known

  // ---------------------------------------------------------------
  // Bus slave state
  // ---------------------------------------------------------------
  logic [31:0]         prdata_r;
  logic [31:0]         prdata_nxt;
  logic                pready_r;
  logic                pready_nxt;
  logic                pslverr_r;
  logic                pslverr_nxt;
  logic                setup;
  logic                wr_go;

  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready_r & pwrite & ~pslverr_r;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  pwm_da_pkg::data_t   data_a_r;
  pwm_da_pkg::data_t   data_a_nxt;
  pwm_da_pkg::data_t   data_b_r;
  pwm_da_pkg::data_t   data_b_nxt;
  pwm_da_pkg::ctrl_t   ctrl_r;
  pwm_da_pkg::ctrl_t   ctrl_nxt;
  pwm_da_pkg::count_t  free_running_counter_r;
  pwm_da_pkg::count_t  free_running_counter_nxt;
  logic                half_r;
  logic                half_nxt;
  logic                tick;

  logic                clock_select_bit;
  logic                phase_select_bit;
  logic                output_enable_a;
  logic                output_enable_b;
  logic                run_control_bit;

  assign clock_select_bit = ctrl_r[`CTRL_CLKSEL_BIT];
  assign phase_select_bit = ctrl_r[`CTRL_PHASE_BIT];
  assign output_enable_a  = ctrl_r[`CTRL_OE_A_BIT];
  assign output_enable_b  = ctrl_r[`CTRL_OE_B_BIT];
  assign run_control_bit  = ctrl_r[`CTRL_RUN_BIT];

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  always_comb
  begin
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup)
    begin
      pready_nxt  = 1'b1;
      pslverr_nxt = ~addr_known(paddr);
      case (paddr)
        `OFF_DATA_A: prdata_nxt = {16'h0000, data_a_r};
        `OFF_DATA_B: prdata_nxt = {16'h0000, data_b_r};
        `OFF_CTRL:   prdata_nxt = {24'h000000, ctrl_r};
        `OFF_COUNT:  prdata_nxt = {18'h00000, free_running_counter_r};
        default:     prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_comb
  begin
    data_a_nxt = data_a_r;
    data_b_nxt = data_b_r;
    ctrl_nxt   = ctrl_r;
    if (wr_go)
    begin
      case (paddr)
        `OFF_DATA_A: data_a_nxt = pwdata[15:0] & `DATA_WR_MASK;
        `OFF_DATA_B: data_b_nxt = pwdata[15:0] & `DATA_WR_MASK;
        `OFF_CTRL:   ctrl_nxt   = (pwdata[7:0] & `CTRL_WR_MASK) | `CTRL_RSVD_MASK;
        default:     ctrl_nxt   = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_a_r <= `RST_DATA;
      data_b_r <= `RST_DATA;
      ctrl_r   <= `RST_CTRL;
    end
    else
    begin
      data_a_r <= data_a_nxt;
      data_b_r <= data_b_nxt;
      ctrl_r   <= ctrl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Time unit and shared counter
  // ---------------------------------------------------------------
  assign tick = ~clock_select_bit | half_r;

  always_comb
  begin
    half_nxt                 = clock_select_bit & ~half_r;
    free_running_counter_nxt = free_running_counter_r;
    if (run_control_bit)
    begin
      free_running_counter_nxt = `COUNT_HOLD;
      half_nxt                 = 1'b0;
    end
    else if (wr_go && paddr == `OFF_COUNT)
    begin
      free_running_counter_nxt = pwdata[13:0];
    end
    else if (tick)
    begin
      free_running_counter_nxt = free_running_counter_r + 14'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_r                 <= 1'b0;
      free_running_counter_r <= `RST_COUNT;
    end
    else
    begin
      half_r                 <= half_nxt;
      free_running_counter_r <= free_running_counter_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  pulse_channel u_chan_a
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .count            (free_running_counter_r),
    .data             (data_a_r),
    .phase_select_bit (phase_select_bit),
    .output_enable    (output_enable_a),
    .pin_r            (pulse_pin_a),
    .pin_oe_r         (pulse_pin_a_oe)
  );

  pulse_channel u_chan_b
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .count            (free_running_counter_r),
    .data             (data_b_r),
    .phase_select_bit (phase_select_bit),
    .output_enable    (output_enable_b),
    .pin_r            (pulse_pin_b),
    .pin_oe_r         (pulse_pin_b_oe)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  chk_count_hold: assert property (
    run_control_bit |=> free_running_counter_r == `COUNT_HOLD)
    else $error("counter not held at 0003");

  chk_count_step: assert property (
    presetn && !run_control_bit && !clock_select_bit && !wr_go ##1 !run_control_bit
      |-> free_running_counter_r == $past(free_running_counter_r) + 14'h0001)
    else $error("counter did not step each clock");

  chk_slow_unit: assert property (
    clock_select_bit && !run_control_bit && !wr_go && !half_r
      |=> free_running_counter_r == $past(free_running_counter_r))
    else $error("counter stepped twice in one slow unit");

  chk_pin_a_off: assert property (
    !output_enable_a ##1 !output_enable_a |-> !pulse_pin_a && !pulse_pin_a_oe)
    else $error("channel A drives while disabled");

  chk_pin_b_off: assert property (
    !output_enable_b ##1 !output_enable_b |-> !pulse_pin_b && !pulse_pin_b_oe)
    else $error("channel B drives while disabled");

  chk_hold_low: assert property (
    output_enable_a && !phase_select_bit && data_a_r[`DATA_CYCSEL_BIT] &&
      data_a_r <= `HOLD_MAX_LONG ##1 $stable(ctrl_r) && $stable(data_a_r)
      |-> !pulse_pin_a)
    else $error("small value did not hold output low");

  chk_hold_high: assert property (
    output_enable_a && phase_select_bit && !data_a_r[`DATA_CYCSEL_BIT] &&
      data_a_r <= `HOLD_MAX_SHORT ##1 $stable(ctrl_r) && $stable(data_a_r)
      |-> pulse_pin_a)
    else $error("inverted small value did not hold output high");

  chk_ready_once: assert property (
    setup |=> pready_r ##1 !pready_r)
    else $error("ready not a single cycle after setup");

  chk_ctrl_write: assert property (
    wr_go && paddr == `OFF_CTRL
      |=> ctrl_r == (($past(pwdata[7:0]) & `CTRL_WR_MASK) | `CTRL_RSVD_MASK))
    else $error("control write not stored");

  // ---------------------------------------------------------------
  // Register, bus, pin enable, counter and time unit checks, and covers
  // ---------------------------------------------------------------

  chk_oe_a_follow: assert property (
    output_enable_a |=> pulse_pin_a_oe)
    else $error("channel A enable not on its pin");

  chk_oe_b_follow: assert property (
    output_enable_b |=> pulse_pin_b_oe)
    else $error("channel B enable not on its pin");

  chk_half_flip: assert property (
    clock_select_bit && !run_control_bit |=> half_r != $past(half_r))
    else $error("slow time unit phase did not alternate");

  chk_half_stop: assert property (
    run_control_bit |=> !half_r)
    else $error("time unit phase not cleared while held");

  chk_count_load: assert property (
    wr_go && paddr == `OFF_COUNT && !run_control_bit
      |=> free_running_counter_r == $past(pwdata[13:0]))
    else $error("counter write not loaded");

  chk_rsvd_ones: assert property (
    (ctrl_r & `CTRL_RSVD_MASK) == `CTRL_RSVD_MASK)
    else $error("reserved control bits not one");

  chk_data_low_bit: assert property (
    !data_a_r[0] && !data_b_r[0])
    else $error("data register bit 0 not zero");

  chk_err_unmapped: assert property (
    setup && !addr_known(paddr) |=> pready_r && pslverr_r)
    else $error("unmapped access not refused");

  chk_err_known: assert property (
    setup && addr_known(paddr) |=> pready_r && !pslverr_r)
    else $error("mapped access refused");

  chk_read_ctrl: assert property (
    setup && paddr == `OFF_CTRL |=> prdata_r == {24'h000000, $past(ctrl_r)})
    else $error("control read data wrong");

  chk_data_a_write: assert property (
    wr_go && paddr == `OFF_DATA_A
      |=> data_a_r == ($past(pwdata[15:0]) & `DATA_WR_MASK))
    else $error("channel A data write not stored");

  chk_data_b_write: assert property (
    wr_go && paddr == `OFF_DATA_B
      |=> data_b_r == ($past(pwdata[15:0]) & `DATA_WR_MASK))
    else $error("channel B data write not stored");

  cov_run: cover property (
    !run_control_bit ##1 free_running_counter_r == 14'h3FFF ##1 free_running_counter_r == 14'h0000);

  cov_slow: cover property (clock_select_bit && output_enable_a && pulse_pin_a);

  cov_bad_addr: cover property (pready_r && pslverr_r);

  cov_both_on: cover property (pulse_pin_a_oe && pulse_pin_b_oe && phase_select_bit);

endmodule : pwm_da_pulse_generator

`default_nettype wire

//--- tb/lowpass_filter_model.sv
// Behavioural low-pass filter load that integrates the active time of one pulse pin
`default_nettype none

module lowpass_filter_model
(
  input  wire logic        pclk,
  input  wire logic        clear,
  input  wire logic        active_level,
  input  wire logic        pin,
  input  wire logic        pin_oe,
  output var  logic [15:0] active_cycles
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Charge integrator
  // ---------------------------------------------------------------
  // An undriven pin adds no charge whatever level it shows
  always_ff @(posedge pclk)
  begin
    if (clear)
      active_cycles <= 16'h0000;
    else if (pin_oe === 1'b1 && pin === active_level)
      active_cycles <= active_cycles + 16'h0001;
  end

endmodule : lowpass_filter_model

`default_nettype wire

//--- tb/pwm_da_pulse_generator_tb.sv
// Self-checking bench of the pulse D/A generator with two filter loads
`default_nettype none
`include "pwm_da_map.svh"

module pwm_da_pulse_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_a;
  logic        pin_a_oe;
  logic        pin_b;
  logic        pin_b_oe;
  logic        filt_clear;
  logic        filt_level;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  int          err_total;
  int          check_count;
  int          cyc;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        er;

  pwm_da_pulse_generator u_dut
  (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .pulse_pin_a    (pin_a),
    .pulse_pin_a_oe (pin_a_oe),
    .pulse_pin_b    (pin_b),
    .pulse_pin_b_oe (pin_b_oe)
  );

  lowpass_filter_model u_filt_a
  (
    .pclk          (pclk),
    .clear         (filt_clear),
    .active_level  (filt_level),
    .pin           (pin_a),
    .pin_oe        (pin_a_oe),
    .active_cycles (cnt_a)
  );

  lowpass_filter_model u_filt_b
  (
    .pclk          (pclk),
    .clear         (filt_clear),
    .active_level  (filt_level),
    .pin           (pin_b),
    .pin_oe        (pin_b_oe),
    .active_cycles (cnt_b)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total = err_total + 1;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ---------------------------------------------------------------
  // APB master
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One full conversion cycle of active time on both channels
  task automatic measure(input logic lvl, input logic [31:0] exp_a, input logic [31:0] exp_b);
    filt_level <= lvl;
    repeat (4) @(posedge pclk);
    filt_clear <= 1'b1;
    @(posedge pclk);
    filt_clear <= 1'b0;
    repeat (16384) @(posedge pclk);
    #1;
    check("active a", {16'h0000, cnt_a}, exp_a);
    check("active b", {16'h0000, cnt_b}, exp_b);
  endtask : measure

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    filt_clear = 1'b0;
    filt_level = 1'b0;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;

    apb(1'b0, `OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h00000030);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", {31'h0, er}, 32'h00000001);
    apb(1'b1, `OFF_CTRL, 32'h00000000);
    apb(1'b0, `OFF_CTRL, 32'h0);
    check("ctrl reserved", rd, 32'h00000030);
    apb(1'b1, `OFF_DATA_A, 32'h0000FFFF);
    apb(1'b0, `OFF_DATA_A, 32'h0);
    check("data a bit0", rd, 32'h0000FFFE);
    $display("test registers done");

    apb(1'b1, `OFF_CTRL, 32'h00000040);
    apb(1'b1, `OFF_COUNT, 32'h00001000);
    apb(1'b0, `OFF_COUNT, 32'h0);
    check("count held", rd, 32'h00000003);
    apb(1'b1, `OFF_CTRL, 32'h00000000);
    apb(1'b1, `OFF_COUNT, 32'h00001000);
    apb(1'b0, `OFF_COUNT, 32'h0);
    check("count load", rd, 32'h00001001);
    apb(1'b0, `OFF_COUNT, 32'h0);
    apb(1'b0, `OFF_COUNT, 32'h0);
    rd2 = rd;
    apb(1'b0, `OFF_COUNT, 32'h0);
    check("count step", {18'h0, rd[13:0] - rd2[13:0]}, 32'h00000003);
    apb(1'b1, `OFF_CTRL, 32'h00000001);
    apb(1'b0, `OFF_COUNT, 32'h0);
    rd2 = rd;
    repeat (7) @(posedge pclk);
    apb(1'b0, `OFF_COUNT, 32'h0);
    check("count half", {18'h0, rd[13:0] - rd2[13:0]}, 32'h00000005);
    $display("test counter done");

    apb(1'b1, `OFF_DATA_A, 32'h00000207);
    apb(1'b1, `OFF_DATA_B, 32'h00000404);
    apb(1'b1, `OFF_CTRL, 32'h0000000E);
    measure(1'b1, 32'd129, 32'd257);
    $display("test inverted done");

    apb(1'b1, `OFF_DATA_A, 32'h000000FE);
    apb(1'b1, `OFF_DATA_B, 32'h000003FC);
    apb(1'b1, `OFF_CTRL, 32'h0000000C);
    measure(1'b0, 32'd16384, 32'd16384);
    $display("test hold done");

    apb(1'b1, `OFF_DATA_A, 32'h000003FC);
    apb(1'b1, `OFF_DATA_B, 32'h000000FE);
    apb(1'b1, `OFF_CTRL, 32'h0000000E);
    measure(1'b1, 32'd16384, 32'd16384);
    $display("test inverted hold done");

    apb(1'b1, `OFF_CTRL, 32'h00000008);
    repeat (4) @(posedge pclk);
    #1;
    check("pin a off", {30'h0, pin_a, pin_a_oe}, 32'h00000000);
    check("pin b on", {31'h0, pin_b_oe}, 32'h00000001);
    $display("test enable done");
    results();
  end

endmodule : pwm_da_pulse_generator_tb

`default_nettype wire
